/* File: cmlg_regs.vh */
// register offsets, field positions, reset values and decodes for the clock mode control slice
// assumes the cpu presents full 20-bit byte addresses on its memory bus
`ifndef CMLG_REGS_VH
`define CMLG_REGS_VH
`define CMLG_ADDR_WIDTH 20
`define CMLG_CLOCK_PIN_MODE_CONTROL_ADDR 20'hfffa0
`define CMLG_CLOCK_PIN_MODE_CONTROL_RESET 8'h00
`define CMLG_EXTERNAL_CLOCK_PIN_BIT 7
`define CMLG_OSCILLATOR_PIN_SELECT_BIT 6
`define CMLG_X1_GAIN_HIGH_BIT 0
`define CMLG_CLOCK_PIN_MODE_CONTROL_MASK 8'hc1
`define CMLG_PINMODE_PORT 2'h0
`define CMLG_PINMODE_X1_OSC 2'h1
`define CMLG_PINMODE_PORT_ALT 2'h2
`define CMLG_PINMODE_EXT_CLK 2'h3
`define CMLG_SYNC_STAGES 2
`endif

/* File: cmlg_sync.v */
// two-flop synchroniser for a single level from outside the clk domain
// assumes clk is the system clock and rstn an asynchronous active-low reset
`timescale 1ns/1ns
module cmlg_sync (
    input wire clk,
    input wire rstn,
    input wire asyncIn,
    output wire syncOut
);
    reg stage1_reg;
    reg stage2_reg;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;
endmodule // cmlg_sync

/* File: cmlg_clock_mode_control.v */
// clock pin mode register with one write per reset, low-speed oscillator gating, main clock select
// assumes cpu bus signals are synchronous to clk; option bits come from outside and are synchronised
`timescale 1ns/1ns
`include "cmlg_regs.vh"

module cmlg_clock_mode_control (
    input wire clk,
    input wire rstn,
    input wire [19:0] busAddr,
    input wire busWrite,
    input wire busRead,
    input wire busByte,
    input wire [7:0] busWdata,
    output reg [7:0] busRdata,
    output wire busAck,
    input wire watchdogEnableOption,
    input wire watchdogStandbyRunOption,
    input wire intervalTimerLowclkSelect,
    input wire standbyActive,
    input wire highSpeedSysOscStopBit,
    input wire mainClockSourceSelect,
    output reg lowSpeedInternalOscEn,
    output reg lowSpeedToWatchdog,
    output reg lowSpeedToIntervalTimer,
    output reg x1OscEnable,
    output reg x1GainHigh,
    output reg firstPinIsPort,
    output reg secondPinIsPort,
    output reg externalClockEnable,
    output reg mainClockIsHighSpeedSys,
    output reg writeOnceUsed
);
    // write-once tracking: armed by reset, locked by the first byte write
    localparam [1:0] WR_ARMED = 2'b01;
    localparam [1:0] WR_LOCKED = 2'b10;

    reg [7:0] clockPinMode_reg;
    reg [7:0] clockPinMode_next;
    reg [1:0] writeState_reg;
    reg [1:0] writeState_next;
    reg [7:0] busRdata_next;
    reg lowSpeedEn_next;
    reg lowSpeedWd_next;
    reg lowSpeedIt_next;
    reg x1OscEnable_next;
    reg externalClockEnable_next;
    reg firstPinIsPort_next;
    reg secondPinIsPort_next;
    wire wdOnSync;
    wire wdStbySync;
    wire regHit;
    wire byteWrite;
    wire byteRead;
    wire writeTaken;
    wire writeLocked;
    wire [1:0] pinMode;
    wire loscRequest;
    wire loscStandbyStop;

    // option-byte bits arrive as levels from the flash option logic, treated as async
    cmlg_sync uWdOn (
        .clk(clk),
        .rstn(rstn),
        .asyncIn(watchdogEnableOption),
        .syncOut(wdOnSync)
    );
    cmlg_sync uWdStby (
        .clk(clk),
        .rstn(rstn),
        .asyncIn(watchdogStandbyRunOption),
        .syncOut(wdStbySync)
    );

    assign regHit = (busAddr == `CMLG_CLOCK_PIN_MODE_CONTROL_ADDR);
    // single-cycle answer for any access to this address
    assign busAck = regHit & (busWrite | busRead);
    // other access widths are acknowledged but neither store nor return data
    assign byteWrite = regHit & busWrite & busByte;
    assign byteRead = regHit & busRead & busByte;
    // any code other than armed refuses the write, so a corrupted state fails safe
    assign writeLocked = (writeState_reg != WR_ARMED);
    assign writeTaken = byteWrite & !writeLocked;
    assign pinMode = {clockPinMode_reg[`CMLG_EXTERNAL_CLOCK_PIN_BIT],
                      clockPinMode_reg[`CMLG_OSCILLATOR_PIN_SELECT_BIT]};

    always @* begin
        writeState_next = writeState_reg;
        case (writeState_reg)
            WR_ARMED: begin
                if (byteWrite) begin
                    writeState_next = WR_LOCKED;
                end
            end
            WR_LOCKED: begin
                // only reset leaves this state
                writeState_next = WR_LOCKED;
            end
            default: begin
                // locking rather than re-arming keeps a glitch from opening a second write
                writeState_next = WR_LOCKED;
            end
        endcase
    end

    always @* begin
        clockPinMode_next = clockPinMode_reg;
        // the write is consumed even when it stores zero, so a runaway loop cannot rewrite it
        if (writeTaken) begin
            clockPinMode_next = busWdata & `CMLG_CLOCK_PIN_MODE_CONTROL_MASK;
        end
    end

    always @* begin
        busRdata_next = 8'h00;
        if (byteRead) begin
            busRdata_next = clockPinMode_reg;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clockPinMode_reg <= `CMLG_CLOCK_PIN_MODE_CONTROL_RESET;
            writeState_reg <= WR_ARMED;
            busRdata <= 8'h00;
        end else begin
            clockPinMode_reg <= clockPinMode_next;
            writeState_reg <= writeState_next;
            busRdata <= busRdata_next;
        end
    end

    assign loscRequest = wdOnSync | intervalTimerLowclkSelect;
    assign loscStandbyStop = standbyActive & wdOnSync & !intervalTimerLowclkSelect & !wdStbySync;

    always @* begin
        lowSpeedEn_next = loscRequest & !loscStandbyStop;
        // only these two consumers get the slow clock; no cpu select path exists
        lowSpeedWd_next = wdOnSync & lowSpeedEn_next;
        lowSpeedIt_next = intervalTimerLowclkSelect & loscRequest;
    end

    // decode of the two mode bits; the gain bit is independent of the mode
    always @* begin
        x1OscEnable_next = 1'b0;
        externalClockEnable_next = 1'b0;
        firstPinIsPort_next = 1'b1;
        secondPinIsPort_next = 1'b1;
        case (pinMode)
            `CMLG_PINMODE_PORT, `CMLG_PINMODE_PORT_ALT: begin
                // both port codes leave the pins to the port logic
                firstPinIsPort_next = 1'b1;
                secondPinIsPort_next = 1'b1;
            end
            `CMLG_PINMODE_X1_OSC: begin
                x1OscEnable_next = !highSpeedSysOscStopBit;
                firstPinIsPort_next = 1'b0;
                secondPinIsPort_next = 1'b0;
            end
            `CMLG_PINMODE_EXT_CLK: begin
                externalClockEnable_next = !highSpeedSysOscStopBit;
                secondPinIsPort_next = 1'b0;
            end
            default: begin
                firstPinIsPort_next = 1'b1;
                secondPinIsPort_next = 1'b1;
            end
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lowSpeedInternalOscEn <= 1'b0;
            lowSpeedToWatchdog <= 1'b0;
            lowSpeedToIntervalTimer <= 1'b0;
        end else begin
            lowSpeedInternalOscEn <= lowSpeedEn_next;
            lowSpeedToWatchdog <= lowSpeedWd_next;
            lowSpeedToIntervalTimer <= lowSpeedIt_next;
        end
    end

    // pin functions follow the stored mode one cycle after the write lands
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            x1OscEnable <= 1'b0;
            x1GainHigh <= 1'b0;
            firstPinIsPort <= 1'b1;
            secondPinIsPort <= 1'b1;
            externalClockEnable <= 1'b0;
        end else begin
            x1OscEnable <= x1OscEnable_next;
            x1GainHigh <= clockPinMode_reg[`CMLG_X1_GAIN_HIGH_BIT];
            firstPinIsPort <= firstPinIsPort_next;
            secondPinIsPort <= secondPinIsPort_next;
            externalClockEnable <= externalClockEnable_next;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mainClockIsHighSpeedSys <= 1'b0;
            writeOnceUsed <= 1'b0;
        end else begin
            // main clock choice is high-speed system or internal fast osc only, never the slow one
            mainClockIsHighSpeedSys <= mainClockSourceSelect;
            // lags the lock by one cycle, in step with the decoded pin outputs
            writeOnceUsed <= writeLocked;
        end
    end
endmodule // cmlg_clock_mode_control

/* File: cmlg_chk_assertions.sv */
// port-level checker for the clock mode slice
// assumes it is bound onto cmlg_clock_mode_control
`timescale 1ns/1ns
module cmlg_chk (
    input wire clk, rstn, busWrite, busRead, busByte, busAck, writeOnceUsed, x1GainHigh, x1OscEnable,
    input wire externalClockEnable, firstPinIsPort, intervalTimerLowclkSelect, watchdogEnableOption,
    input wire standbyActive, watchdogStandbyRunOption, lowSpeedInternalOscEn, lowSpeedToIntervalTimer,
    input wire lowSpeedToWatchdog,
    input wire [19:0] busAddr,
    input wire [7:0] busWdata, busRdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire hit = busAddr == 20'hfffa0;
    // a write right after the taken one is refused before writeOnceUsed can show it
    logic prevWrite;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prevWrite <= 1'b0;
        end else begin
            prevWrite <= busWrite && busByte && hit;
        end
    end
    wire take = busWrite && busByte && hit && !writeOnceUsed && !prevWrite;
    ack_decode_a: assert property ((busWrite || busRead) |-> busAck == hit) else $error("bad ack");
    once_hold_a: assert property ($past(writeOnceUsed) |-> $stable(x1GainHigh)) else $error("gain moved");
    gain_set_a: assert property (take |-> ##2 x1GainHigh == $past(busWdata[0], 2)) else $error("gain");
    rd_zero_a: assert property (busRead && hit |=> busRdata[5:1] == 5'h0) else $error("bits 5..1");
    rd_unmap_a: assert property (busRead && !hit |=> busRdata == 8'h0) else $error("unmapped read");
    slow_on_a: assert property (
        intervalTimerLowclkSelect |=> lowSpeedInternalOscEn && lowSpeedToIntervalTimer) else $error("slow osc off");
    slow_off_a: assert property (
        (!intervalTimerLowclkSelect && !watchdogEnableOption)[*4] |=> !lowSpeedInternalOscEn)
        else $error("slow osc on");
    stby_stop_a: assert property (
        (standbyActive && !intervalTimerLowclkSelect && !watchdogStandbyRunOption)[*4] |=> !lowSpeedInternalOscEn)
        else $error("standby stop");
    wd_gate_a: assert property (lowSpeedToWatchdog |-> lowSpeedInternalOscEn) else $error("watchdog slow clock");
    mode_excl_a: assert property (x1OscEnable |-> !externalClockEnable && !firstPinIsPort) else $error("mode");
endmodule // cmlg_chk

/* File: cmlg_cpu_model.sv */
// cpu side: byte and wide accesses to the clock mode slice
// assumes the design samples the bus on the rising edge of clk
`timescale 1ns/1ns
module cmlg_cpu_model (
    input wire clk,
    output logic [19:0] busAddr,
    output logic busWrite, busRead, busByte,
    output logic [7:0] busWdata
);
    initial {busAddr, busWrite, busRead, busByte, busWdata} = '0;
    // one access per call to any address; released bus shows inverted address, byte flag and data with both strobes low
    task acc(input logic w, input logic b, input logic [19:0] a, input logic [7:0] d);
        @(posedge clk); #1;
        {busAddr, busWrite, busRead, busByte, busWdata} = {a, w, !w, b, d};
        @(posedge clk); #1;
        {busAddr, busWrite, busRead, busByte, busWdata} = {~a, 2'b00, ~b, ~d};
    endtask
    // the gain bit follows the resonator frequency, so software never leaves it low above 10 MHz
    task pin_mode_write(input logic [1:0] mode, input int resonatorKhz);
        acc(1'b1, 1'b1, 20'hfffa0, {mode, 5'h00, resonatorKhz > 10000});
    endtask
endmodule // cmlg_cpu_model

/* File: tb_top.sv */
// testbench for the clock mode slice
// assumes cmlg_cpu_model drives the bus and cmlg_chk is bound
`timescale 1ns/1ns
module tb_top;
    logic clk = 0, rstn = 0, watchdogEnableOption = 0, watchdogStandbyRunOption = 0;
    logic intervalTimerLowclkSelect = 0, standbyActive = 0, highSpeedSysOscStopBit = 1, mainClockSourceSelect = 0;
    logic [19:0] busAddr;
    logic [7:0] busWdata, busRdata;
    logic busWrite, busRead, busByte, busAck, lowSpeedInternalOscEn, lowSpeedToWatchdog, lowSpeedToIntervalTimer;
    logic x1OscEnable, x1GainHigh, firstPinIsPort, secondPinIsPort, externalClockEnable, mainClockIsHighSpeedSys;
    logic writeOnceUsed;
    int error_cnt = 0, comparisons = 0;
    initial forever #4 clk = ~clk;
    cmlg_cpu_model i_cpu (.*);
    cmlg_clock_mode_control i_dut (.*);
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task rd(input logic [19:0] a, input logic [7:0] e, input string n);
        i_cpu.acc(1'b0, 1'b1, a, 8'h00);
        chk(n, busRdata, e);
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        finish_test;
    end
    initial begin
        step(8);
        rstn = 1;
        chk("pin1", firstPinIsPort, 1);
        rd(20'hfffa0, 8'h00, "reset");
        i_cpu.acc(1'b1, 1'b0, 20'hfffa0, 8'hff);
        rd(20'hfffa0, 8'h00, "wide");
        rd(20'hfffa1, 8'h00, "unmapped");
        i_cpu.acc(1'b1, 1'b1, 20'hfffa0, 8'hff);
        i_cpu.acc(1'b1, 1'b1, 20'hfffa0, 8'h40);
        highSpeedSysOscStopBit = 0;
        rd(20'hfffa0, 8'hc1, "once");
        chk("gain", x1GainHigh, 1);
        chk("ext", externalClockEnable, 1);
        chk("pin2", secondPinIsPort, 0);
        chk("pin1", firstPinIsPort, 1);
        $display("end write-once test");
        rstn = 0;
        step(2);
        rstn = 1;
        highSpeedSysOscStopBit = 1;
        rd(20'hfffa0, 8'h00, "rearm");
        i_cpu.pin_mode_write(2'h1, 8000);
        highSpeedSysOscStopBit = 0;
        step(2);
        chk("x1", x1OscEnable, 1);
        chk("gain", x1GainHigh, 0);
        $display("end resonator test");
        intervalTimerLowclkSelect = 1;
        step(2);
        chk("slowIt", lowSpeedToIntervalTimer, 1);
        chk("slowWd", lowSpeedToWatchdog, 0);
        {intervalTimerLowclkSelect, watchdogEnableOption, standbyActive} = 3'h3;
        step(6);
        chk("slowStby", lowSpeedInternalOscEn, 0);
        watchdogStandbyRunOption = 1;
        mainClockSourceSelect = 1;
        step(6);
        chk("slowRun", lowSpeedInternalOscEn, 1);
        chk("mainHs", mainClockIsHighSpeedSys, 1);
        chk("slowWdRun", lowSpeedToWatchdog, 1);
        $display("end clock gating test");
        rstn = 0;
        mainClockSourceSelect = 0;
        step(2);
        rstn = 1;
        step(1);
        chk("used0", writeOnceUsed, 0);
        i_cpu.pin_mode_write(2'h0, 0);
        i_cpu.acc(1'b1, 1'b1, 20'hfffa0, 8'h41);
        rd(20'hfffa0, 8'h00, "zeroKept");
        chk("used", writeOnceUsed, 1);
        chk("x1off", x1OscEnable, 0);
        $display("end runaway guard test");
        finish_test;
    end
endmodule // tb_top
bind cmlg_clock_mode_control cmlg_chk u_chk (.*);
